// ### hw/swbl_pkg.sv
// Purpose: shared constants and types of the one-wire level receiver
// Assumes: sys_clk at 250 MHz
// Notes:   times are kept in their own unit; cycle counts derive from them
`default_nettype none
package swbl_pkg;
    localparam int CLK_MHZ          = 250;
    localparam int CNT_W            = 12;
    localparam int START_NS         = 2000;
    localparam int EOS_NS           = 2000;
    localparam int ACK_VALID_NS     = 4000;
    localparam int ACK_PULSE_US     = 512;
    // least times round up
    localparam logic [CNT_W-1:0] START_CYC =
        CNT_W'((START_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] EOS_CYC =
        CNT_W'((EOS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] ACK_VALID_CYC =
        CNT_W'((ACK_VALID_NS * CLK_MHZ + 999) / 1000);
    // longest time rounds down
    localparam int ACK_PULSE_CYC_DFLT = ACK_PULSE_US * CLK_MHZ;
    localparam int ACK_W            = 17;
    // data byte fields
    localparam int ACK_REQ_POS      = 7;
    localparam int SEL_HI_POS       = 6;
    localparam int SEL_LO_POS       = 5;
    localparam int LVL_MSB_POS      = 4;
    localparam int LVL_W            = 5;
    localparam int NUM_LVL          = 4;
    localparam int CMD_W            = 7;
    localparam int FIFO_DEPTH       = 16;
    localparam logic [LVL_W-1:0] LVL_RST = 5'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    typedef enum logic [2:0] {
        SWBL_IDLE = 3'h0,
        SWBL_BITS = 3'h1,
        SWBL_EOS  = 3'h3,
        SWBL_GAP  = 3'h2,
        SWBL_VAL  = 3'h6,
        SWBL_ACK  = 3'h7
    } swbl_state_e;
endpackage
`default_nettype wire

// ### hw/swbl_stream_if.sv
// Purpose: valid/ready word stream between the receiver and its fifo
// Assumes: one clock domain
// Notes:   src drives valid and data, snk drives ready
`default_nettype none
interface swbl_stream_if #(parameter int W = 7);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hw/swbl_fifo.sv
// Purpose: word fifo with registered read data
// Assumes: depth is a power of two
// Notes:   an output register sits behind the array, so depth+1 words fit
`default_nettype none
module swbl_fifo #(
    parameter int W = 7,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst_b,
    // streams
    swbl_stream_if.snk  wr,
    swbl_stream_if.src  rd
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ov_q, ov_d;
    logic [W-1:0]  od_q, od_d;
    logic          push, load;

    assign wr.ready = (cnt_q != (AW+1)'(D));
    assign rd.valid = ov_q;
    assign rd.data  = od_q;

    always_comb begin
        push   = wr.valid && wr.ready;
        load   = (cnt_q != '0) && (!ov_q || rd.ready);
        wptr_d = push ? wptr_q + 1'b1 : wptr_q;
        rptr_d = load ? rptr_q + 1'b1 : rptr_q;
        cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        ov_d   = load ? 1'b1 : (rd.ready ? 1'b0 : ov_q);
        od_d   = load ? mem[rptr_q] : od_q;
    end

    // array kept without reset; pointers, count and output valid carry control state
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr_q] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
            ov_q   <= 1'b0;
            od_q   <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q  <= cnt_d;
            ov_q   <= ov_d;
            od_q   <= od_d;
        end
    end
endmodule // swbl_fifo
`default_nettype wire

// ### hw/swbl_rx.sv
// Purpose: one-wire address/data receiver with open-drain acknowledge
// Assumes: host pulls the line up; sys_clk at 250 MHz
// Notes:   decoded commands pass a fifo before reaching the level registers
`default_nettype none

// Overview of operation
// - bytes shift in msb first
// - address byte accepted without separate start
// - bit runs falling edge to falling edge
// - decide bit by two-to-one phase ratio
// - acknowledge needs request, address match, 16 bits
// - acknowledge drives line low for pulse time
// - pull-down starts after validation delay
// - data byte: request, select, five-bit value
// - acknowledge is open-drain, active low
// - first byte compared with own address
module swbl_rx
    import swbl_pkg::*;
#(
    parameter logic [7:0] DEV_ADDR      = 8'hA5, // arbitrary value
    parameter int         ACK_PULSE_CYC = ACK_PULSE_CYC_DFLT
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    // one-wire control line
    input  wire logic                        line_in,
    output logic                             line_out,
    output logic                             line_oe,
    // level register side
    input  wire logic                        apply_en,
    output logic [NUM_LVL*LVL_W-1:0]         level_values,
    output logic                             frame_drop
);
    swbl_stream_if #(.W(CMD_W)) cmd_in ();
    swbl_stream_if #(.W(CMD_W)) cmd_out ();

    swbl_state_e                  st_q, st_d;
    logic                         s1_q, s2_q, s3_q;
    logic [CNT_W-1:0]             low_q, low_d, high_q, high_d;
    logic [7:0]                   sh_q, sh_d;
    logic [2:0]                   bits_q, bits_d;
    logic                         byte1_q, byte1_d;
    logic                         match_q, match_d;
    logic [ACK_W-1:0]             ackc_q, ackc_d;
    logic                         drop_q, drop_d;
    logic [NUM_LVL-1:0][LVL_W-1:0] lvl_q, lvl_d;
    logic                         fall, bit_one, bit_zero, push;
    logic [CNT_W-1:0]             low_inc, high_inc;

    swbl_fifo #(
        .W (CMD_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .wr      (cmd_in),
        .rd      (cmd_out)
    );

    // s1 feeds only s2; edges are taken from s2 against s3
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= line_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        fall     = s3_q && !s2_q;
        low_inc  = (low_q == '1) ? low_q : low_q + 1'b1;
        high_inc = (high_q == '1) ? high_q : high_q + 1'b1;
        bit_one  = {1'b0, high_q} >= {low_q, 1'b0};
        bit_zero = {1'b0, low_q} >= {high_q, 1'b0};
        st_d     = st_q;
        low_d    = low_q;
        high_d   = high_q;
        sh_d     = sh_q;
        bits_d   = bits_q;
        byte1_d  = byte1_q;
        match_d  = match_q;
        ackc_d   = ackc_q;
        drop_d   = 1'b0;
        push     = 1'b0;
        case (st_q)
            SWBL_IDLE: begin
                // a falling edge from a high line opens the address byte
                if (fall) begin
                    st_d    = SWBL_BITS;
                    low_d   = '0;
                    high_d  = '0;
                    bits_d  = '0;
                    byte1_d = 1'b0;
                end
            end
            SWBL_BITS: begin
                if (fall) begin
                    low_d  = '0;
                    high_d = '0;
                    bits_d = bits_q + 1'b1;
                    if (bit_one) begin
                        sh_d = {sh_q[6:0], 1'b1};
                    end else if (bit_zero) begin
                        sh_d = {sh_q[6:0], 1'b0};
                    end
                    if (!bit_one && !bit_zero) begin
                        st_d = SWBL_IDLE;
                    end else if (bits_q == BIT_LAST) begin
                        st_d = SWBL_EOS;
                    end
                end else if (s2_q) begin
                    high_d = high_inc;
                    // a high phase this long mid-byte means a lost frame
                    if (high_q >= START_CYC) begin
                        st_d = SWBL_IDLE;
                    end
                end else begin
                    low_d = low_inc;
                end
            end
            SWBL_EOS: begin
                if (low_q >= EOS_CYC) begin
                    if (!byte1_q) begin
                        match_d = (sh_q == DEV_ADDR);
                        st_d    = SWBL_GAP;
                    end else begin
                        st_d = SWBL_IDLE;
                        if (match_q) begin
                            push   = cmd_in.ready;
                            drop_d = !cmd_in.ready;
                            if (cmd_in.ready && sh_q[ACK_REQ_POS]) begin
                                st_d = SWBL_VAL;
                            end
                        end
                    end
                end else if (s2_q) begin
                    st_d = SWBL_IDLE;
                end else begin
                    low_d = low_inc;
                end
            end
            SWBL_GAP: begin
                if (fall) begin
                    st_d    = SWBL_BITS;
                    low_d   = '0;
                    high_d  = '0;
                    bits_d  = '0;
                    byte1_d = 1'b1;
                end
            end
            SWBL_VAL: begin
                // delay runs from the last falling edge, line ignored
                low_d = low_inc;
                if (low_q >= ACK_VALID_CYC) begin
                    st_d   = SWBL_ACK;
                    ackc_d = '0;
                end
            end
            SWBL_ACK: begin
                ackc_d = ackc_q + 1'b1;
                if (ackc_q == ACK_W'(ACK_PULSE_CYC - 1)) begin
                    st_d = SWBL_IDLE;
                end
            end
            default: begin
                st_d = SWBL_IDLE;
            end
        endcase
    end

    // commands carry select and value; the request bit stays behind
    assign cmd_in.valid = push;
    assign cmd_in.data  = sh_q[SEL_HI_POS:0];
    assign cmd_out.ready = apply_en;

    always_comb begin
        lvl_d = lvl_q;
        if (cmd_out.valid && apply_en) begin
            lvl_d[cmd_out.data[SEL_HI_POS:SEL_LO_POS]] =
                cmd_out.data[LVL_MSB_POS:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q    <= SWBL_IDLE;
            low_q   <= '0;
            high_q  <= '0;
            sh_q    <= '0;
            bits_q  <= '0;
            byte1_q <= 1'b0;
            match_q <= 1'b0;
            ackc_q  <= '0;
            drop_q  <= 1'b0;
            lvl_q   <= {NUM_LVL{LVL_RST}};
        end else begin
            st_q    <= st_d;
            low_q   <= low_d;
            high_q  <= high_d;
            sh_q    <= sh_d;
            bits_q  <= bits_d;
            byte1_q <= byte1_d;
            match_q <= match_d;
            ackc_q  <= ackc_d;
            drop_q  <= drop_d;
            lvl_q   <= lvl_d;
        end
    end

    // never drive high: the host's pull-up restores the line
    assign line_out     = 1'b0;
    assign line_oe      = (st_q == SWBL_ACK);
    assign level_values = lvl_q;
    assign frame_drop   = drop_q;
endmodule // swbl_rx
`default_nettype wire

// ### verification/swbl_rx_assertions.sv
// Purpose: port-level checks of the one-wire receiver
// Assumes: pull-up on the line, one clock
// Notes:   counters stand in for long repetitions
`default_nettype none
module swbl_rx_assertions
    import swbl_pkg::*;
#(
    parameter int ACK_PULSE_CYC = ACK_PULSE_CYC_DFLT
) (
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst_b,
    // line and level side
    input wire logic                     line_in,
    input wire logic                     line_out,
    input wire logic                     line_oe,
    input wire logic                     apply_en,
    input wire logic [NUM_LVL*LVL_W-1:0] level_values,
    input wire logic                     frame_drop
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ACK_W-1:0] oe_cnt_q;
    logic [CNT_W-1:0] lo_cnt_q;
    logic [CNT_W-1:0] drop_age_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_cnt_q   <= '0;
            lo_cnt_q   <= '0;
            drop_age_q <= '1;
        end else begin
            oe_cnt_q   <= line_oe ? oe_cnt_q + 1'b1 : '0;
            lo_cnt_q   <= line_in ? '0 : lo_cnt_q + (&lo_cnt_q ? 1'b0 : 1'b1);
            drop_age_q <= frame_drop ? '0
                        : drop_age_q + (&drop_age_q ? 1'b0 : 1'b1);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_oe_drives_low: assert property (line_oe |-> !line_out)
        else $error("line enabled while not driving low");
    chk_ack_pulse_len: assert property (
        $fell(line_oe) |-> oe_cnt_q == ACK_W'(ACK_PULSE_CYC))
        else $error("acknowledge pulse length wrong");
    chk_ack_holds_on: assert property ($rose(line_oe) |=> line_oe [*8])
        else $error("acknowledge pulse cut short");
    chk_ack_valid_delay: assert property ($rose(line_oe) |->
        lo_cnt_q >= ACK_VALID_CYC && lo_cnt_q <= ACK_VALID_CYC + 8)
        else $error("acknowledge start not after validation delay");
    chk_drop_no_ack: assert property (
        $rose(line_oe) |-> drop_age_q > 12'h4B0)
        else $error("acknowledge after a dropped frame");
    chk_drop_one_cycle: assert property (frame_drop |=> !frame_drop)
        else $error("drop pulse longer than one cycle");
    chk_drop_quiet_ack: assert property (line_oe |-> !frame_drop)
        else $error("drop during acknowledge");
    chk_level_apply_en: assert property ($changed(level_values) |->
        ($past(apply_en) || $past(apply_en, 2)))
        else $error("level changed while stalled");
    cov_ack: cover property ($rose(line_oe));
    cov_drop: cover property (frame_drop);
    cov_level: cover property ($changed(level_values));
endmodule // swbl_rx_assertions
bind swbl_rx swbl_rx_assertions #(.ACK_PULSE_CYC(ACK_PULSE_CYC))
    swbl_rx_assertions_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .apply_en(apply_en), .level_values(level_values),
    .frame_drop(frame_drop));
`default_nettype wire

// ### verification/swbl_host.sv
// Purpose: open-drain host that sends address and data frames
// Assumes: line pulled up, edges at the falling clock edge
// Notes:   bad_bit picks one frame bit sent with a 1:1 ratio
`default_nettype none
module swbl_host (
    // clock and resolved line
    input  wire logic sys_clk,
    input  wire logic line,
    // high pulls the line low
    output logic      host_low
);
    timeunit 1ns;
    timeprecision 1ps;
    int bad_bit = -1;
    initial host_low = 1'b0;
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic send_byte(input logic [7:0] b, input int first);
        int lo;
        int hi;
        for (int i = 7; i >= 0; i--) begin
            lo = b[i] ? 8 : 20;
            hi = b[i] ? 20 : 8;
            if (first + 7 - i == bad_bit) begin
                lo = 15;
                hi = 15;
            end
            host_low = 1'b1;
            wait_cyc(lo);
            host_low = 1'b0;
            wait_cyc(hi);
        end
        host_low = 1'b1;
        wait_cyc(510);
    endtask
    // open-drain driver, so asking for acknowledge is allowed
    task automatic send_frame(input logic [7:0] a, input logic [7:0] d,
                              output logic ack);
        int n;
        send_byte(a, 0);
        host_low = 1'b0;
        wait_cyc(510);
        send_byte(d, 8);
        wait_cyc(500);
        host_low = 1'b0;
        wait_cyc(3);
        ack = !line;
        n = 0;
        while (!line && n < 1000) begin
            wait_cyc(1);
            n++;
        end
        wait_cyc(20);
    endtask
endmodule // swbl_host
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench of the one-wire receiver
// Assumes: short acknowledge pulse parameter
// Notes:   fifo test stalls the level side to fill all 17 places
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import swbl_pkg::*;
    localparam logic [7:0] ADDR = 8'hA5; // arbitrary value
    logic                     sys_clk;
    logic                     rst_b;
    logic                     apply_en;
    logic                     host_low;
    logic                     line_out;
    logic                     line_oe;
    logic                     frame_drop;
    logic [NUM_LVL*LVL_W-1:0] level_values;
    logic [NUM_LVL*LVL_W-1:0] lv0;
    logic [LVL_W-1:0]         exp_lvl [NUM_LVL];
    logic [7:0]               d;
    int                       miscompares;
    int                       comparisons;
    int                       drops;
    wire line_w = !(host_low || (line_oe && !line_out));
    swbl_rx #(.DEV_ADDR(ADDR), .ACK_PULSE_CYC(50)) swbl_rx_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .line_in(line_w),
        .line_out(line_out), .line_oe(line_oe), .apply_en(apply_en),
        .level_values(level_values), .frame_drop(frame_drop));
    swbl_host swbl_host_i (.sys_clk(sys_clk), .line(line_w),
        .host_low(host_low));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = !sys_clk;
    end
    // pulse is launched on the rising edge, so look at it mid-cycle
    always @(negedge sys_clk) if (frame_drop === 1'b1) drops++;
    function automatic logic [NUM_LVL*LVL_W-1:0] packed_exp();
        for (int i = 0; i < NUM_LVL; i++) begin
            packed_exp[i*LVL_W +: LVL_W] = exp_lvl[i];
        end
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("ERROR t=%0t got=%0h want=%0h", $time, got, want);
        end
    endtask
    task automatic frame(input logic [7:0] a, input logic [7:0] dd,
                         input logic ok);
        logic ack;
        swbl_host_i.send_frame(a, dd, ack);
        check(32'(ack), 32'(ok && dd[7]));
        if (ok) exp_lvl[dd[6:5]] = dd[4:0];
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    initial begin
        rst_b = 1'b0;
        apply_en = 1'b1;
        for (int i = 0; i < NUM_LVL; i++) exp_lvl[i] = LVL_RST;
        d = 8'(0 * $urandom(32'h8271));
        repeat (16) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge sys_clk);
        check(32'(level_values), 32'h0);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            // alternate the request bit so frames with and without acknowledge are exercised
            d[7] = i[0];
            frame(ADDR, d, 1'b1);
            check(32'(level_values), 32'(packed_exp()));
        end
        $display("test random frames done");
        frame(ADDR ^ 8'h01, 8'hFF, 1'b0);
        frame(ADDR ^ 8'h80, 8'hDE, 1'b0);
        check(32'(level_values), 32'(packed_exp()));
        $display("test address mismatch done");
        swbl_host_i.bad_bit = 15;
        frame(ADDR, 8'hDF, 1'b0);
        swbl_host_i.bad_bit = -1;
        check(32'(level_values), 32'(packed_exp()));
        $display("test bad ratio done");
        lv0 = packed_exp();
        apply_en = 1'b0;
        for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
            frame(ADDR, 8'($urandom) & 8'h7F, 1'b1);
        end
        frame(ADDR, 8'hE5, 1'b0);
        check(32'(drops), 32'h1);
        check(32'(level_values), 32'(lv0));
        apply_en = 1'b1;
        repeat (40) @(negedge sys_clk);
        check(32'(level_values), 32'(packed_exp()));
        $display("test fifo full done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
